// [src/bgp_regs.svh]
// Offsets, bank codes, reset values and timing counts of the banked GPIO port
`ifndef BGP_REGS_SVH
`define BGP_REGS_SVH

// ***************************************
// Data memory offsets
// ***************************************
`define BGP_ADDR_PORT_A     8'h05
`define BGP_ADDR_PORT_B     8'h06
`define BGP_ADDR_PORT_C     8'h07

// ***************************************
// Bank select codes
// ***************************************
`define BGP_BANK_CMP        8'h08
`define BGP_BANK_WKPND      8'h09
`define BGP_BANK_WKED       8'h0a
`define BGP_BANK_WKEN       8'h0b
`define BGP_BANK_SCHMITT    8'h0c
`define BGP_BANK_LEVEL      8'h0d
`define BGP_BANK_PULLUP     8'h0e
`define BGP_BANK_DIR        8'h0f

// ***************************************
// Reset values and field layout
// ***************************************
`define BGP_MODE_RESET      8'h0f
`define BGP_CFG_RESET       8'hff
`define BGP_DATA_RESET      8'h00
`define BGP_PA_MASK         8'h0f
`define BGP_PA_UPPER_ONES   8'hf0
`define BGP_CMP_RES_BIT     0

// ***************************************
// Timing counts
// ***************************************
`define BGP_WB_CYCLES       2'h3

`endif

// [src/bgp_pkg.sv]
// Types of the banked GPIO port
package bgp_pkg;

    typedef logic [7:0] bgp_byte_t;
    typedef logic [1:0] bgp_cnt_t;

    typedef enum logic [1:0] {
        BGP_PA = 2'b00,
        BGP_PB = 2'b01,
        BGP_PC = 2'b10
    } bgp_port_e;

    typedef struct packed {
        bgp_byte_t           mode;
        bgp_byte_t [2:0]     dat;
        bgp_byte_t [2:0]     oe;
        bgp_byte_t [2:0]     plp;
        bgp_byte_t [2:0]     lvl;
        bgp_byte_t [2:0]     st;
        bgp_byte_t [2:0]     s1;
        bgp_byte_t [2:0]     s2;
        bgp_cnt_t  [2:0]     wb;
        bgp_byte_t           wken;
        bgp_byte_t           wked;
        bgp_byte_t           wkpnd;
        bgp_byte_t           wk_prev;
        bgp_byte_t           cmp;
        logic                cmp_s1;
        logic                cmp_s2;
        bgp_byte_t           rdata;
        bgp_byte_t           pc_rdata;
    } bgp_state_s;

endpackage

// [src/bgp_port.sv]
// Banked GPIO port: data registers, banked pin configuration and port B wakeup
//
// Contract
// - Port A four pins, B eight, C optional eight
// - Bit zero maps to lowest pin number
// - Port A upper four bits ignored
// - Configuration bits all one after reset
// - Data registers at 05h, 06h, 07h
// - Data write drives output pins
// - Data read returns pin levels
// - Input pin write still updates latch
// - Output held low externally reads zero
// - Write-back keeps successive bit operations consistent
// - Port-control write targets port, bank picks register
// - Bank select unmapped, loaded and read specially
// - Bank select resets to 0Fh
// - Bank select persists until rewritten
// - Bank map 08h to 0Fh as listed
// - Pullup bit one disconnects, zero connects
// - Direction bit one input, zero output
// - Schmitt option only on ports B, C
// - Level bit one TTL, zero CMOS
// - Wakeup enable bit zero enables detection
// - Wakeup edge bit zero rising, one falling
// - Pending bit set on selected valid edge
`include "bgp_regs.svh"

module bgp_port #(
    parameter bit HAS_PORT_C = 1'b1
) (
    // Clock and reset
    input  wire logic            MCLK,
    input  wire logic            RST_B,
    // Data memory access
    input  wire logic [7:0]      DM_ADDR,
    input  wire logic            DM_WE,
    input  wire logic            DM_RE,
    input  wire bgp_pkg::bgp_byte_t DM_WDATA,
    output bgp_pkg::bgp_byte_t   DM_RDATA,
    // Bank select instructions
    input  wire logic            MODE_WE,
    input  wire bgp_pkg::bgp_byte_t MODE_WDATA,
    output bgp_pkg::bgp_byte_t   MODE_Q,
    // Port-control write instruction
    input  wire logic            PC_WE,
    input  wire bgp_pkg::bgp_port_e PC_PORT,
    input  wire bgp_pkg::bgp_byte_t PC_WDATA,
    output bgp_pkg::bgp_byte_t   PC_RDATA,
    // Port A pins
    input  wire logic [3:0]      PA_IN,
    output logic [3:0]           PA_OUT,
    output logic [3:0]           PA_OE,
    // Port B pins
    input  wire logic [7:0]      PB_IN,
    output logic [7:0]           PB_OUT,
    output logic [7:0]           PB_OE,
    // Port C pins
    input  wire logic [7:0]      PC_IN,
    output logic [7:0]           PC_OUT,
    output logic [7:0]           PC_OE,
    // Pad configuration
    output logic [3:0]           PULLUP_DIS_A,
    output logic [7:0]           PULLUP_DIS_B,
    output logic [7:0]           PULLUP_DIS_C,
    output logic [3:0]           LEVEL_TTL_A,
    output logic [7:0]           LEVEL_TTL_B,
    output logic [7:0]           LEVEL_TTL_C,
    output logic [7:0]           SCHMITT_DIS_B,
    output logic [7:0]           SCHMITT_DIS_C,
    // Wakeup and comparator
    output logic [7:0]           WAKE_PENDING,
    output logic [7:0]           CMP_CTRL,
    input  wire logic            CMP_RES
);
    import bgp_pkg::*;

    bgp_state_s st;
    bgp_state_s next_st;
    bgp_byte_t  pins_in [3];
    bgp_byte_t  wake_hit;
    logic       dm_hit  [3];
    logic       pc_ok;

    // ***************************************
    // Pin input gathering
    // ***************************************
    assign pins_in[0] = {4'h0, PA_IN};
    assign pins_in[1] = PB_IN;
    assign pins_in[2] = HAS_PORT_C ? PC_IN : 8'h00;

    assign dm_hit[0] = (DM_ADDR == `BGP_ADDR_PORT_A);
    assign dm_hit[1] = (DM_ADDR == `BGP_ADDR_PORT_B);
    assign dm_hit[2] = HAS_PORT_C && (DM_ADDR == `BGP_ADDR_PORT_C);

    // Code 11 names no port; keeps the register index in range
    assign pc_ok = (PC_PORT == BGP_PA) || (PC_PORT == BGP_PB) || (HAS_PORT_C && PC_PORT == BGP_PC);

    // Edge seen on synchronised pins only, never on the first stage
    assign wake_hit = ~st.wken & (
        ( st.s2[1] & ~st.wk_prev & ~st.wked) |
        (~st.s2[1] &  st.wk_prev &  st.wked));

    // ***************************************
    // Next state
    // ***************************************
    always_comb begin
        bgp_byte_t w;
        bgp_byte_t merged;
        w = PC_WDATA;
        merged = 8'h00;
        next_st = st;

        // Two-stage synchronisers on all pin inputs
        for (int p = 0; p < 3; p++) begin
            next_st.s1[p] = pins_in[p];
            next_st.s2[p] = st.s1[p];
            if (st.wb[p] != 2'h0) begin
                next_st.wb[p] = st.wb[p] - 2'h1;
            end
        end
        next_st.cmp_s1 = CMP_RES;
        next_st.cmp_s2 = st.cmp_s1;
        next_st.wk_prev = st.s2[1];

        // Pending flags: a new edge wins over an exchange in the same cycle
        next_st.wkpnd = st.wkpnd | wake_hit;

        // Bank select load, held otherwise
        if (MODE_WE) begin
            next_st.mode = MODE_WDATA;
        end

        // Data writes update the latch whatever the direction
        for (int p = 0; p < 3; p++) begin
            if (DM_WE && dm_hit[p]) begin
                next_st.dat[p] = (p == 0) ? (DM_WDATA & `BGP_PA_MASK) : DM_WDATA;
                next_st.wb[p] = `BGP_WB_CYCLES;
            end
        end

        // Data read: pins, except freshly written outputs still in the synchroniser
        next_st.rdata = 8'h00;
        for (int p = 0; p < 3; p++) begin
            if (DM_RE && dm_hit[p]) begin
                merged = st.s2[p];
                if (st.wb[p] != 2'h0) begin
                    merged = (st.dat[p] & st.oe[p]) | (st.s2[p] & ~st.oe[p]);
                end
                next_st.rdata = (p == 0) ? (merged & `BGP_PA_MASK) : merged;
            end
        end

        // Port-control write steered by the bank select
        next_st.pc_rdata = 8'h00;
        if (PC_WE && pc_ok) begin
            unique case (st.mode)
                `BGP_BANK_DIR: begin
                    next_st.oe[PC_PORT] = (PC_PORT == BGP_PA) ? (~w & `BGP_PA_MASK) : ~w;
                end
                `BGP_BANK_PULLUP: begin
                    next_st.plp[PC_PORT] = (PC_PORT == BGP_PA) ? (w | `BGP_PA_UPPER_ONES) : w;
                end
                `BGP_BANK_LEVEL: begin
                    next_st.lvl[PC_PORT] = (PC_PORT == BGP_PA) ? (w | `BGP_PA_UPPER_ONES) : w;
                end
                `BGP_BANK_SCHMITT: begin
                    if (PC_PORT != BGP_PA) begin
                        next_st.st[PC_PORT] = w;
                    end
                end
                `BGP_BANK_WKEN: begin
                    if (PC_PORT == BGP_PB) begin
                        next_st.wken = w;
                    end
                end
                `BGP_BANK_WKED: begin
                    if (PC_PORT == BGP_PB) begin
                        next_st.wked = w;
                    end
                end
                `BGP_BANK_WKPND: begin
                    if (PC_PORT == BGP_PB) begin
                        next_st.pc_rdata = st.wkpnd;
                        next_st.wkpnd = w | wake_hit;
                    end
                end
                `BGP_BANK_CMP: begin
                    if (PC_PORT == BGP_PB) begin
                        next_st.pc_rdata = {st.cmp[7:1], st.cmp_s2};
                        next_st.cmp = {w[7:1], 1'b0};
                    end
                end
                // Reserved codes change nothing
                default: begin
                    next_st.pc_rdata = 8'h00;
                end
            endcase
        end
    end

    // ***************************************
    // State register
    // ***************************************
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            st <= '0;
            st.mode <= `BGP_MODE_RESET;
            for (int p = 0; p < 3; p++) begin
                st.dat[p] <= `BGP_DATA_RESET;
                st.oe[p]  <= 8'h00;
                st.plp[p] <= `BGP_CFG_RESET;
                st.lvl[p] <= `BGP_CFG_RESET;
                st.st[p]  <= `BGP_CFG_RESET;
            end
            st.wken <= `BGP_CFG_RESET;
            st.wked <= `BGP_CFG_RESET;
            st.cmp  <= `BGP_CFG_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ***************************************
    // Outputs, each a flop slice
    // ***************************************
    assign DM_RDATA      = st.rdata;
    assign MODE_Q        = st.mode;
    assign PC_RDATA      = st.pc_rdata;
    assign PA_OUT        = st.dat[0][3:0];
    assign PA_OE         = st.oe[0][3:0];
    assign PB_OUT        = st.dat[1];
    assign PB_OE         = st.oe[1];
    assign PC_OUT        = st.dat[2];
    assign PC_OE         = st.oe[2];
    assign PULLUP_DIS_A  = st.plp[0][3:0];
    assign PULLUP_DIS_B  = st.plp[1];
    assign PULLUP_DIS_C  = st.plp[2];
    assign LEVEL_TTL_A   = st.lvl[0][3:0];
    assign LEVEL_TTL_B   = st.lvl[1];
    assign LEVEL_TTL_C   = st.lvl[2];
    assign SCHMITT_DIS_B = st.st[1];
    assign SCHMITT_DIS_C = st.st[2];
    assign WAKE_PENDING  = st.wkpnd;
    assign CMP_CTRL      = st.cmp;

    // ***************************************
    // Assertions
    // ***************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    a_mode_hold: assert property (!MODE_WE |=> $stable(MODE_Q))
        else $error("bank select changed without a load");
    a_mode_load: assert property (MODE_WE |=> MODE_Q == $past(MODE_WDATA))
        else $error("bank select did not load");
    a_dir_write: assert property (PC_WE && MODE_Q == `BGP_BANK_DIR && PC_PORT == BGP_PB
        |=> PB_OE == ~$past(PC_WDATA))
        else $error("direction write did not set output enables");
    a_data_drive: assert property (DM_WE && DM_ADDR == `BGP_ADDR_PORT_B
        |=> PB_OUT == $past(DM_WDATA))
        else $error("data write did not reach the latch");
    a_read_pins: assert property (DM_RE && DM_ADDR == `BGP_ADDR_PORT_B && st.wb[1] == 2'h0
        |=> DM_RDATA == $past(st.s2[1]))
        else $error("port read did not return pin levels");
    a_pa_upper: assert property (DM_RE && DM_ADDR == `BGP_ADDR_PORT_A |=> DM_RDATA[7:4] == 4'h0)
        else $error("port A upper bits not zero");
    a_pullup_write: assert property (PC_WE && MODE_Q == `BGP_BANK_PULLUP && PC_PORT == BGP_PA
        |=> PULLUP_DIS_A == $past(PC_WDATA[3:0]))
        else $error("pullup write lost");
    a_wake_set: assert property (wake_hit != 8'h00
        |=> (WAKE_PENDING & $past(wake_hit)) == $past(wake_hit))
        else $error("wakeup edge did not set pending");
    a_wb_merge: assert property (DM_WE && DM_ADDR == `BGP_ADDR_PORT_B ##1 DM_RE && DM_ADDR == `BGP_ADDR_PORT_B
        |=> ((DM_RDATA ^ $past(PB_OUT)) & $past(PB_OE)) == 8'h00)
        else $error("write-back read disagrees with latch");

    c_dir_then_data: cover property (PC_WE && MODE_Q == `BGP_BANK_DIR ##[1:4] DM_WE);
    c_wake_edge: cover property (wake_hit != 8'h00);
    c_pend_exchange: cover property (PC_WE && MODE_Q == `BGP_BANK_WKPND && PC_PORT == BGP_PB);

endmodule

// [bench/bgp_pins_model.sv]
// Board model of the pads of all three ports
module bgp_pins_model (
    // Pad drivers of the design, port C in the top byte
    input  wire logic [2:0][7:0] oe,
    input  wire logic [2:0][7:0] out,
    // Board circuitry
    input  wire logic [2:0][7:0] ext,
    input  wire logic [2:0][7:0] hold,
    // Pad levels
    output logic [2:0][7:0]      pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // ***************************************
    // Pad resolution
    // ***************************************
    // Held bits win over a driven high, as a strong short to ground would
    assign pin = ~hold & ((oe & out) | (~oe & ext));
endmodule

// [bench/test_banked_gpio_port_config.sv]
// Self-checking bench of the banked GPIO port
`include "bgp_regs.svh"

module test_banked_gpio_port_config;
    timeunit 1ns;
    timeprecision 1ps;
    import bgp_pkg::*;

    typedef struct packed {
        logic [7:0] m;
        bgp_port_e  p;
        bgp_byte_t  w;
        bgp_byte_t  e;
    } bgp_row_s;

    logic MCLK = 0, RST_B = 0, DM_WE = 0, DM_RE = 0, MODE_WE = 0, PC_WE = 0, CMP_RES = 0;
    logic [7:0] DM_ADDR = 0;
    bgp_byte_t DM_WDATA = 0, MODE_WDATA = 0, PC_WDATA = 0, DM_RDATA, MODE_Q, PC_RDATA;
    bgp_port_e PC_PORT = BGP_PA;
    logic [3:0] PA_OUT, PA_OE, PULLUP_DIS_A, LEVEL_TTL_A;
    logic [7:0] PB_OUT, PB_OE, PC_OUT, PC_OE, PULLUP_DIS_B, PULLUP_DIS_C, LEVEL_TTL_B, LEVEL_TTL_C;
    logic [7:0] SCHMITT_DIS_B, SCHMITT_DIS_C, WAKE_PENDING, CMP_CTRL;
    logic [2:0][7:0] ext = '0, hold = '0, pin, oe_w, out_w, plp_w, lvl_w, st_w;
    int mismatches = 0, checked = 0, cycles = 0;
    bgp_row_s rows [11] = '{
        '{8'h0e, BGP_PA, 8'h03, 8'h03}, '{8'h0e, BGP_PB, 8'hff, 8'hff}, '{8'h0e, BGP_PC, 8'h00, 8'h00},
        '{8'h0d, BGP_PA, 8'hf5, 8'h05}, '{8'h0d, BGP_PB, 8'ha5, 8'ha5}, '{8'h0d, BGP_PC, 8'h3c, 8'h3c},
        '{8'h0c, BGP_PB, 8'h0f, 8'h0f}, '{8'h0c, BGP_PC, 8'hf0, 8'hf0}, '{8'h0f, BGP_PA, 8'hfa, 8'h0a},
        '{8'h0f, BGP_PB, 8'h55, 8'h55}, '{8'h0f, BGP_PC, 8'h0f, 8'h0f}};

    assign oe_w  = {PC_OE, PB_OE, 4'h0, PA_OE};
    assign out_w = {PC_OUT, PB_OUT, 4'h0, PA_OUT};
    assign plp_w = {PULLUP_DIS_C, PULLUP_DIS_B, 4'h0, PULLUP_DIS_A};
    assign lvl_w = {LEVEL_TTL_C, LEVEL_TTL_B, 4'h0, LEVEL_TTL_A};
    assign st_w  = {SCHMITT_DIS_C, SCHMITT_DIS_B, 8'h00};

    bgp_port #(.HAS_PORT_C(1'b1)) dut (
        .MCLK(MCLK), .RST_B(RST_B), .DM_ADDR(DM_ADDR), .DM_WE(DM_WE), .DM_RE(DM_RE),
        .DM_WDATA(DM_WDATA), .DM_RDATA(DM_RDATA), .MODE_WE(MODE_WE), .MODE_WDATA(MODE_WDATA),
        .MODE_Q(MODE_Q), .PC_WE(PC_WE), .PC_PORT(PC_PORT), .PC_WDATA(PC_WDATA), .PC_RDATA(PC_RDATA),
        .PA_IN(pin[0][3:0]), .PA_OUT(PA_OUT), .PA_OE(PA_OE), .PB_IN(pin[1]), .PB_OUT(PB_OUT),
        .PB_OE(PB_OE), .PC_IN(pin[2]), .PC_OUT(PC_OUT), .PC_OE(PC_OE), .PULLUP_DIS_A(PULLUP_DIS_A),
        .PULLUP_DIS_B(PULLUP_DIS_B), .PULLUP_DIS_C(PULLUP_DIS_C), .LEVEL_TTL_A(LEVEL_TTL_A),
        .LEVEL_TTL_B(LEVEL_TTL_B), .LEVEL_TTL_C(LEVEL_TTL_C), .SCHMITT_DIS_B(SCHMITT_DIS_B),
        .SCHMITT_DIS_C(SCHMITT_DIS_C), .WAKE_PENDING(WAKE_PENDING), .CMP_CTRL(CMP_CTRL), .CMP_RES(CMP_RES));

    bgp_pins_model pins (.oe(oe_w), .out(out_w), .ext(ext), .hold(hold), .pin(pin));

    // ***************************************
    // Clock, timeout and shared tasks
    // ***************************************
    always #4 MCLK = ~MCLK;

    // Whole run needs well under a thousand cycles
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            finish_test();
        end
    end

    task check(input bgp_byte_t got, input bgp_byte_t exp);
        checked++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask

    task dm_write(input logic [7:0] a, input bgp_byte_t d);
        @(negedge MCLK);
        DM_ADDR = a;
        DM_WDATA = d;
        DM_WE = 1;
        @(negedge MCLK);
        DM_WE = 0;
    endtask

    task dm_read(input logic [7:0] a, input bgp_byte_t exp);
        @(negedge MCLK);
        DM_ADDR = a;
        DM_RE = 1;
        @(negedge MCLK);
        DM_RE = 0;
        check(DM_RDATA, exp);
    endtask

    task mode_set(input bgp_byte_t v);
        @(negedge MCLK);
        MODE_WDATA = v; // Only codes 08h to 0Fh are ever loaded
        MODE_WE = 1;
        @(negedge MCLK);
        MODE_WE = 0;
    endtask

    task pc_write(input bgp_port_e p, input bgp_byte_t w);
        @(negedge MCLK);
        PC_PORT = p;
        PC_WDATA = w;
        PC_WE = 1;
        @(negedge MCLK);
        PC_WE = 0;
    endtask

    function automatic bgp_byte_t cfg(input logic [7:0] m, input bgp_port_e p);
        bgp_byte_t g;
        case (m)
            `BGP_BANK_DIR:    g = ~oe_w[p];
            `BGP_BANK_PULLUP: g = plp_w[p];
            `BGP_BANK_LEVEL:  g = lvl_w[p];
            default:          g = st_w[p];
        endcase
        return (p == BGP_PA) ? (g & `BGP_PA_MASK) : g;
    endfunction

    task finish_test;
        $display("Checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ***************************************
    // Main sequence
    // ***************************************
    initial begin
        repeat (3) @(negedge MCLK);
        RST_B = 1;
        check(MODE_Q, `BGP_MODE_RESET);
        check(oe_w[0] | oe_w[1] | oe_w[2], 8'h00);
        check(plp_w[0] & lvl_w[0], 8'h0f);
        check(plp_w[1] & plp_w[2] & lvl_w[1] & lvl_w[2] & st_w[1] & st_w[2], 8'hff);
        check(CMP_CTRL, `BGP_CFG_RESET);
        check(WAKE_PENDING, 8'h00);
        $display("Test reset done");
        // Bank changes only when a row needs it, so persistence is seen too
        foreach (rows[i]) begin
            if (MODE_Q !== rows[i].m)
                mode_set(rows[i].m);
            pc_write(rows[i].p, rows[i].w);
            check(MODE_Q, rows[i].m);
            check(cfg(rows[i].m, rows[i].p), rows[i].e);
        end
        $display("Test bank rows done");
        pc_write(BGP_PB, 8'h00);
        dm_write(`BGP_ADDR_PORT_B, 8'h5a);
        check(PB_OUT, 8'h5a);
        check(PB_OE, 8'hff);
        repeat (5) @(negedge MCLK);
        hold[1] = 8'h02;
        repeat (4) @(negedge MCLK);
        dm_read(`BGP_ADDR_PORT_B, 8'h58);
        hold[1] = 8'h00;
        pc_write(BGP_PC, 8'hff);
        ext[2] = 8'hc3;
        dm_write(`BGP_ADDR_PORT_C, 8'h3c);
        check(PC_OUT, 8'h3c);
        check(PC_OE, 8'h00);
        repeat (4) @(negedge MCLK);
        dm_read(`BGP_ADDR_PORT_C, 8'hc3);
        pc_write(BGP_PC, 8'h00);
        check(PC_OE & PC_OUT, 8'h3c);
        repeat (4) @(negedge MCLK);
        dm_read(`BGP_ADDR_PORT_C, 8'h3c);
        dm_write(`BGP_ADDR_PORT_A, 8'hff);
        check({4'h0, PA_OUT}, 8'h0f);
        repeat (4) @(negedge MCLK);
        dm_read(`BGP_ADDR_PORT_A, 8'h05);
        dm_write(`BGP_ADDR_PORT_B, 8'ha5);
        dm_read(`BGP_ADDR_PORT_B, 8'ha5);
        // Read right behind the write, pins not yet through the synchroniser
        @(negedge MCLK);
        DM_ADDR = `BGP_ADDR_PORT_B;
        DM_WDATA = 8'hc3;
        DM_WE = 1;
        @(negedge MCLK);
        DM_WE = 0;
        DM_RE = 1;
        @(negedge MCLK);
        DM_RE = 0;
        check(DM_RDATA, 8'hc3);
        dm_read(8'h08, 8'h00);
        $display("Test data port done");
        mode_set(`BGP_BANK_DIR);
        pc_write(BGP_PB, 8'hff);
        ext[1] = 8'h00;
        mode_set(`BGP_BANK_WKEN);
        pc_write(BGP_PB, 8'hfe);
        mode_set(`BGP_BANK_WKED);
        pc_write(BGP_PB, 8'h00);
        mode_set(`BGP_BANK_WKPND);
        ext[1] = 8'h03;
        repeat (6) @(negedge MCLK);
        check(WAKE_PENDING, 8'h01);
        pc_write(BGP_PB, 8'h00);
        check(PC_RDATA, 8'h01);
        check(WAKE_PENDING, 8'h00);
        mode_set(`BGP_BANK_WKED);
        pc_write(BGP_PB, 8'h01);
        ext[1] = 8'h00;
        repeat (6) @(negedge MCLK);
        check(WAKE_PENDING, 8'h01);
        $display("Test wakeup done");
        mode_set(`BGP_BANK_CMP);
        CMP_RES = 1;
        repeat (3) @(negedge MCLK);
        pc_write(BGP_PB, 8'h3e);
        check(PC_RDATA, 8'hff);
        check(CMP_CTRL, 8'h3e);
        pc_write(BGP_PA, 8'h00);
        check(PC_RDATA, 8'h00);
        check(CMP_CTRL, 8'h3e);
        $display("Test comparator done");
        // Asynchronous reset in mid-run, seen before any clock edge
        @(negedge MCLK);
        RST_B = 0;
        #1;
        check(MODE_Q, `BGP_MODE_RESET);
        check(PB_OE | PC_OE, 8'h00);
        check(CMP_CTRL | WAKE_PENDING, `BGP_CFG_RESET);
        @(negedge MCLK);
        RST_B = 1;
        mode_set(`BGP_BANK_PULLUP);
        pc_write(BGP_PB, 8'h0f);
        check(PULLUP_DIS_B, 8'h0f);
        $display("Test reset again done");
        finish_test();
    end
endmodule
